// >>> hw/flash_command_lock_control.sv
// Flash command sequencer, ready flags, lock protection and programming port.
// Assumes a CPU register port, an external programmer on pins, and a flash macro.
`timescale 1ns/1ps

module flash_command_lock_control
  import flash_ctl_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter int MASS_CYCLES = ERASE_CYCLES_DEF
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // CPU register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // CPU protection hooks
  input wire logic code_read_external_i,
  output logic internal_fetch_block_o,
  output logic external_access_select_o,
  // External programming port
  input wire ext_pins_s ext_pins_i,
  output logic [7:0] ext_data_o,
  output logic ext_data_oe_o,
  output logic ext_ready_o,
  // Flash array macro
  output flash_req_s flash_req_o,
  input wire logic [7:0] flash_rdata_i
);

  seq_state_e state_r, state_nxt, start_state;
  ext_pins_s ext_s;
  logic [CNT_W-1:0] cnt_r, cnt_load;
  logic [7:0] data_r, addr_hi_r, ext_data_r, sfr_mux;
  logic [5:0] addr_lo_r, cmd_r;
  logic [2:0] lock_r, lock_sel_r, lock_sel_nxt, arm_r;
  logic upper_r, src_ext_r, ext_valid_r, strobe_prev_r, access_latched_r;
  logic [11:0] wr_len_r;

  // ----------------------------------------------------------------
  // Pin synchronisation; setup margin lets the bundle settle together
  // ----------------------------------------------------------------
  pin_sync3 #(.W($bits(ext_pins_s))) u_sync ( // [R5]
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(ext_pins_i),
    .sync_o(ext_s)
  );

  // ----------------------------------------------------------------
  // Decode of requests and protection levels
  // ----------------------------------------------------------------
  wire idle = (state_r == ST_IDLE);
  wire busy_done = !idle && (cnt_r == '0);
  wire cpu_cmd_wr = sfr_wr_i && (sfr_addr_i == ADDR_CMD);
  wire cmd_known = (sfr_wdata_i == CMD_READ) || (sfr_wdata_i == CMD_WRITE)
                   || (sfr_wdata_i == CMD_ERASE); // [R17]
  wire cpu_go = cpu_cmd_wr && idle && cmd_known; // [R3] [R13]
  wire strobe_fall = strobe_prev_r && !ext_s.strobe_n;
  wire ext_edge = strobe_fall && ext_s.prog_en && idle && !cpu_cmd_wr;
  wire lock_one_set = !lock_r[0];
  wire verify_locked = !lock_r[0] && !lock_r[1];
  wire exec_locked = (lock_r == 3'h0);
  wire mode_lock = (ext_s.mode == MODE_LOCK1) || (ext_s.mode == MODE_LOCK2)
                   || (ext_s.mode == MODE_LOCK3);
  wire ext_prog = ext_edge && (ext_s.mode == MODE_PROGRAM) && !lock_one_set; // [R8] [R9]
  wire ext_lock = ext_edge && mode_lock; // [R4]
  wire ext_mass = ext_edge && (ext_s.mode == MODE_MASS);
  wire ext_ver = ext_edge && (ext_s.mode == MODE_VERIFY) && !verify_locked; // [R10]
  wire ext_sig = ext_edge && (ext_s.mode == MODE_SIG);
  wire go_upper = cpu_go ? addr_hi_r[AHI_BLOCK_BIT] : ext_s.block;

  // Which operation starts, CPU first
  assign start_state = cpu_go ? ((sfr_wdata_i == CMD_READ) ? ST_READ :
                                 (sfr_wdata_i == CMD_WRITE) ? ST_WRITE : ST_ERASE) :
                       ext_ver ? ST_READ :
                       (ext_prog || ext_lock) ? ST_WRITE :
                       ext_mass ? ST_MASS : ST_IDLE;

  // Duration of each operation, less one
  assign cnt_load = (start_state == ST_READ) ? CNT_W'(READ_CYCLES - 1) :
                    (start_state == ST_WRITE) ? CNT_W'(WRITE_CYCLES - 1) : // [R6]
                    (start_state == ST_ERASE) ? CNT_W'(ERASE_CYCLES - 1) :
                    CNT_W'(MASS_CYCLES - 1);

  assign lock_sel_nxt = !ext_lock ? 3'h0 :
                        (ext_s.mode == MODE_LOCK1) ? 3'h1 :
                        (ext_s.mode == MODE_LOCK2) ? 3'h2 : 3'h4;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: state_nxt = start_state;
      ST_READ, ST_WRITE, ST_ERASE, ST_MASS: begin
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // State, timer and operation target
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      upper_r <= 1'b0;
      src_ext_r <= 1'b0;
      lock_sel_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      if (idle && start_state != ST_IDLE) begin
        cnt_r <= cnt_load;
        upper_r <= go_upper;
        src_ext_r <= !cpu_go;
        lock_sel_r <= lock_sel_nxt;
      end else if (!idle) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Ready flags and CPU register file
  // ----------------------------------------------------------------
  wire all_blocks = (state_r == ST_MASS);
  wire rdy_hi = !(!idle && (upper_r || all_blocks)); // [R1]
  wire rdy_lo = !(!idle && (!upper_r || all_blocks)); // [R2]

  assign sfr_mux = (sfr_addr_i == ADDR_CMD) ? {rdy_hi, rdy_lo, cmd_r} : // [R3]
                   (sfr_addr_i == ADDR_DATA) ? data_r :
                   (sfr_addr_i == ADDR_AHI) ? addr_hi_r :
                   (sfr_addr_i == ADDR_ALO) ? {2'b00, addr_lo_r} : 8'h00;

  // Register writes; a finishing read overrides a data write
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_r <= DATA_RST;
      addr_hi_r <= AHI_RST;
      addr_lo_r <= ALO_RST;
      cmd_r <= CMD_RST;
      sfr_rdata_o <= 8'h00;
    end else begin
      if (sfr_rd_i) sfr_rdata_o <= sfr_mux;
      if (sfr_wr_i && sfr_addr_i == ADDR_AHI) addr_hi_r <= sfr_wdata_i;
      if (sfr_wr_i && sfr_addr_i == ADDR_ALO) addr_lo_r <= sfr_wdata_i[5:0];
      if (cpu_cmd_wr) cmd_r <= sfr_wdata_i[5:0];
      if (state_r == ST_READ && busy_done && !src_ext_r) begin
        data_r <= flash_rdata_i; // [R15]
      end else if (sfr_wr_i && sfr_addr_i == ADDR_DATA) begin
        data_r <= sfr_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash macro requests: one-cycle strobes, held address and data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flash_req_o <= '0;
    end else begin
      flash_req_o.rd <= idle && start_state == ST_READ;
      flash_req_o.wr <= idle && start_state == ST_WRITE && !ext_lock;
      flash_req_o.erase <= idle && start_state == ST_ERASE;
      flash_req_o.mass <= idle && start_state == ST_MASS;
      if (idle && start_state != ST_IDLE) begin
        flash_req_o.upper <= go_upper;
        flash_req_o.addr <= cpu_go ? {addr_hi_r[6:0], addr_lo_r} : ext_s.addr;
        flash_req_o.wdata <= cpu_go ? data_r : ext_s.data;
        if (start_state == ST_ERASE) flash_req_o.addr[5:0] <= 6'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock bits and latched access pin
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_r <= LOCK_RST;
      arm_r <= 3'h0;
      access_latched_r <= 1'b0;
    end else begin
      if (state_r == ST_MASS && busy_done) begin
        lock_r <= LOCK_RST; // [R16]
      end else if (state_r == ST_WRITE && busy_done) begin
        lock_r <= lock_r & ~lock_sel_r;
      end
      if (arm_r != ACCESS_ARM_DONE) arm_r <= arm_r + 1'b1;
      if (arm_r == ACCESS_ARM_DONE - 3'h1) access_latched_r <= ext_s.access_select; // [R9]
    end
  end

  // Protection outputs
  assign internal_fetch_block_o = lock_one_set && code_read_external_i; // [R9]
  assign external_access_select_o = exec_locked ? 1'b1 : // [R11]
                                    lock_one_set ? access_latched_r : // [R9]
                                    ext_s.access_select;

  // ----------------------------------------------------------------
  // Programming port readback and ready pin
  // ----------------------------------------------------------------
  wire [7:0] sig_byte = (ext_s.addr[7:0] == SIG_ADDR0) ? SIG_CONT : // [R12]
                        (ext_s.addr[7:0] == SIG_ADDR1) ? SIG_MAKER :
                        (ext_s.addr[7:0] == SIG_ADDR2) ? SIG_PART : SIG_NONE;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_data_r <= 8'h00;
      ext_valid_r <= 1'b0;
      strobe_prev_r <= 1'b0;
    end else begin
      strobe_prev_r <= ext_s.strobe_n;
      if (ext_sig) begin
        ext_data_r <= sig_byte;
        ext_valid_r <= 1'b1;
      end else if (state_r == ST_READ && busy_done && src_ext_r) begin
        ext_data_r <= flash_rdata_i; // [R7]
        ext_valid_r <= 1'b1;
      end else if (ext_edge) begin
        ext_valid_r <= 1'b0;
      end
    end
  end

  assign ext_data_o = ext_data_r;
  assign ext_data_oe_o = ext_s.prog_en && ext_valid_r && ext_s.strobe_n &&
                         ((ext_s.mode == MODE_VERIFY && !verify_locked) || // [R10]
                          ext_s.mode == MODE_SIG);
  assign ext_ready_o = !(!idle && src_ext_r);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) wr_len_r <= 12'h000;
    else if (state_r == ST_WRITE) wr_len_r <= wr_len_r + 12'h001;
    else wr_len_r <= 12'h000;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_read_go;
    cpu_go && sfr_wdata_i == CMD_READ;
  endsequence
  sequence s_read_back;
    ##[2:3] (idle && data_r == $past(flash_rdata_i));
  endsequence

  a_upper_ready_drop: assert property (cpu_go && addr_hi_r[AHI_BLOCK_BIT] |=> // [R1]
    !sfr_mux[RDY_HI_BIT] || sfr_addr_i != ADDR_CMD ##0 !rdy_hi && rdy_lo)
    else $error("upper ready flag not dropped");
  a_lower_ready_drop: assert property (cpu_go && !addr_hi_r[AHI_BLOCK_BIT] |=> // [R2]
    !rdy_lo && rdy_hi)
    else $error("lower ready flag not dropped");
  a_read_code_start: assert property (s_read_go |=> state_r == ST_READ) // [R3]
    else $error("read code did not start a read");
  a_read_lands: assert property (s_read_go |-> s_read_back) // [R15]
    else $error("read data not in data register in time");
  a_write_length: assert property ($fell(state_r == ST_WRITE) |-> // [R6]
    wr_len_r == 12'(WRITE_CYCLES))
    else $error("write duration wrong");
  a_verify_access: assert property (ext_ver |-> ##[1:3] // [R7]
    (ext_valid_r && ext_data_r == $past(flash_rdata_i)))
    else $error("verify data late");
  a_open_programs: assert property (lock_r == LOCK_RST && ext_edge && // [R8]
    ext_s.mode == MODE_PROGRAM |=> state_r == ST_WRITE)
    else $error("unlocked part refused programming");
  a_lock_blocks_prog: assert property (lock_one_set && ext_edge && // [R9]
    ext_s.mode == MODE_PROGRAM |=> idle && !flash_req_o.wr)
    else $error("locked part accepted programming");
  a_verify_off: assert property (verify_locked && ext_s.mode == MODE_VERIFY |-> // [R10]
    !ext_data_oe_o)
    else $error("verify readback while locked");
  a_exec_override: assert property (exec_locked && !$past(exec_locked) |-> // [R11]
    external_access_select_o ##1 external_access_select_o)
    else $error("access pin not overridden");
  a_signature_byte: assert property (ext_sig && ext_s.addr[7:0] == SIG_ADDR1 |=> // [R12]
    ext_data_r == SIG_MAKER && ext_valid_r)
    else $error("signature byte wrong");
  a_mass_unlocks: assert property (state_r == ST_MASS && busy_done |=> // [R16]
    lock_r == LOCK_RST && idle)
    else $error("mass erase left lock bits set");
  a_bad_code_idle: assert property (cpu_cmd_wr && idle && !cmd_known && !ext_edge // [R17]
    |=> idle && rdy_hi && rdy_lo)
    else $error("undefined code started an operation");

endmodule : flash_command_lock_control

// >>> hw/flash_ctl_pkg.sv
// Constants, types and layouts shared by the flash command and lock controller.
// Assumes a 50 MHz device clock and an external flash array macro with byte strobes.
//
// Overview of operation
// R1: Upper-block ready flag, bit 7, reads 0 while an operation targets the upper block.
// R2: Lower-block ready flag, bit 6, reads 0 while an operation targets the lower block.
// R3: A command write uses all eight bits; bits 7 and 6 double as ready flags.
// R4: Programmer keeps the program strobe low ten clocks, lock writes a full write time.
// R5: Programmer sets address, data and mode lines three clocks before the strobe falls.
// R6: An external byte write lasts 7 clocks plus 54 to 72 us.
// R7: External verify data is valid within eight clocks plus 50 ns of the request.
// R8: With all three lock bits at 1 nothing is protected.
// R9: Lock bit one programmed: no internal table reads, latched access pin, no programming.
// R10: Lock bits one and two programmed: verify readback is also disabled.
// R11: All lock bits programmed: external execution disabled by overriding the access pin.
// R12: Three read-only signature bytes answer at addresses 30h, 31h and 32h.
// R13: Codes aah read, 55h write and 5ah page erase start operations after address setup.
// R14: Software issues no command while either ready flag reads 0.
// R15: A read places the addressed byte in the data register by the next instruction cycle.
// R16: Mass erase sets every flash bit and all three lock bits to 1.
// R17: An undefined command code starts nothing and leaves both ready flags at 1.

package flash_ctl_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA = 8'hec;
  localparam logic [7:0] ADDR_CMD = 8'hed;
  localparam logic [7:0] ADDR_AHI = 8'hee;
  localparam logic [7:0] ADDR_ALO = 8'hef;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] AHI_RST = 8'h00;
  localparam logic [5:0] ALO_RST = 6'h00;
  localparam logic [5:0] CMD_RST = 6'h00;
  localparam int RDY_HI_BIT = 7;
  localparam int RDY_LO_BIT = 6;
  localparam int AHI_BLOCK_BIT = 7;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'haa;
  localparam logic [7:0] CMD_WRITE = 8'h55;
  localparam logic [7:0] CMD_ERASE = 8'h5a;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_WRITE_BASE_CK = 7;
  localparam int T_WRITE_MIN_NS = 54000;
  localparam int WRITE_CYCLES =
    T_WRITE_BASE_CK + (T_WRITE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES = 2;
  localparam int T_ERASE_NS = 9400000;
  localparam int ERASE_CYCLES_DEF = T_ERASE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 20;
  localparam logic [2:0] ACCESS_ARM_DONE = 3'h4;

  // ----------------------------------------------------------------
  // Signature bytes (values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [7:0] SIG_ADDR0 = 8'h30;
  localparam logic [7:0] SIG_ADDR1 = 8'h31;
  localparam logic [7:0] SIG_ADDR2 = 8'h32;
  localparam logic [7:0] SIG_CONT = 8'h01;
  localparam logic [7:0] SIG_MAKER = 8'h02;
  localparam logic [7:0] SIG_PART = 8'h03;
  localparam logic [7:0] SIG_NONE = 8'hff;

  // ----------------------------------------------------------------
  // External programming modes and lock bits
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_SIG = 4'h0;
  localparam logic [3:0] MODE_PROGRAM = 4'h1;
  localparam logic [3:0] MODE_VERIFY = 4'h2;
  localparam logic [3:0] MODE_MASS = 4'h3;
  localparam logic [3:0] MODE_LOCK1 = 4'h4;
  localparam logic [3:0] MODE_LOCK2 = 4'h5;
  localparam logic [3:0] MODE_LOCK3 = 4'h6;
  localparam logic [2:0] LOCK_RST = 3'h7;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_ERASE = 5'b01000,
    ST_MASS = 5'b10000
  } seq_state_e;

  // Programming port pins as seen after synchronisation
  typedef struct packed {
    logic strobe_n;
    logic prog_en;
    logic access_select;
    logic [3:0] mode;
    logic block;
    logic [12:0] addr;
    logic [7:0] data;
  } ext_pins_s;

  // Request to the flash array macro
  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic mass;
    logic upper;
    logic [12:0] addr;
    logic [7:0] wdata;
  } flash_req_s;

endpackage : flash_ctl_pkg

// >>> hw/pin_sync3.sv
// Three-stage synchroniser for a bundle of pin levels.
// Assumes the bundle is stable for several clocks around each change.
`timescale 1ns/1ps

module pin_sync3 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // ----------------------------------------------------------------
  // Stages; a change counts once stages two and three agree
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          s1_r[b] <= 1'b0;
          s2_r[b] <= 1'b0;
          s3_r[b] <= 1'b0;
          sync_o[b] <= 1'b0;
        end else begin
          s1_r[b] <= async_i[b];
          s2_r[b] <= s1_r[b];
          s3_r[b] <= s2_r[b];
          if (s2_r[b] == s3_r[b]) begin
            sync_o[b] <= s3_r[b];
          end
        end
      end
    end
  endgenerate

endmodule : pin_sync3

// >>> verif/flash_array_model.sv
// Behavioural flash array answering the controller's request pulses.
// Assumes one request pulse at a time, in the controller's clock domain.
`timescale 1ns/1ps

module flash_array_model
  import flash_ctl_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Controller side
  input wire flash_req_s req_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:16383];
  logic [13:0] idx;

  // ----------------------------------------
  // Array storage
  // ----------------------------------------
  // Byte index from block and address
  assign idx = {req_i.upper, req_i.addr};

  // Shipped fully erased
  initial begin
    foreach (mem[i])
      mem[i] = 8'hff;
    rdata_o = 8'h00;
  end

  // Data valid one cycle only, scrambled outside that window
  always @(posedge ref_clk_i) begin
    rdata_o <= req_i.rd ? mem[idx] : ~rdata_o;
    if (req_i.wr)
      mem[idx] <= mem[idx] & req_i.wdata;
    if (req_i.erase)
      for (int i = 0; i < 64; i++)
        mem[{idx[13:6], 6'(i)}] <= 8'hff;
    if (req_i.mass)
      foreach (mem[i])
        mem[i] <= 8'hff;
  end
endmodule : flash_array_model

// >>> verif/testbench.sv
// Self-checking bench for the flash command and lock controller.
// Assumes the array model as far side and shortened erase counts.
`timescale 1ns/1ps

module testbench;
  import flash_ctl_pkg::*;
  typedef struct packed {
    logic [7:0] ahi, alo, wd, cmd, exp;
    logic busy, reqs;
  } row_s;
  localparam int WR_MAX = T_WRITE_BASE_CK + 72000 / CLK_PERIOD_NS;
  localparam row_s ROWS [0:6] = '{
    '{8'h85, 8'h03, 8'h3c, CMD_WRITE, 8'h00, 1'b1, 1'b1},
    '{8'h85, 8'h03, 8'h00, CMD_READ, 8'h3c, 1'b0, 1'b1},
    '{8'h05, 8'h03, 8'hc3, CMD_WRITE, 8'h00, 1'b1, 1'b1},
    '{8'h05, 8'h03, 8'h00, CMD_READ, 8'hc3, 1'b0, 1'b1},
    '{8'h85, 8'h00, 8'h00, CMD_ERASE, 8'h00, 1'b1, 1'b1},
    '{8'h85, 8'h03, 8'h00, CMD_READ, 8'hff, 1'b0, 1'b1},
    '{8'h85, 8'h03, 8'h00, 8'h12, 8'h00, 1'b0, 1'b0}};
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic code_read_external_i = 1'b0;
  ext_pins_s pins = '{1'b1, 1'b0, 1'b0, MODE_VERIFY, 1'b0, 13'h0, 8'h00};
  ext_pins_s pin_bus;
  logic [7:0] sfr_rdata_o, ext_data_o, flash_rdata_i, s;
  logic internal_fetch_block_o, external_access_select_o, ext_data_oe_o, ext_ready_o;
  flash_req_s flash_req_o;
  int miscompares = 0;
  int samples_checked = 0;
  int req_cnt = 0;
  int low_cnt = 0;
  int n0;

  // ----------------------------------------
  // Clock, wire levels and monitors
  // ----------------------------------------
  always #10 ref_clk_i = ~ref_clk_i;

  // Shared data pins follow the device while it drives
  always_comb begin
    pin_bus = pins;
    if (ext_data_oe_o === 1'b1)
      pin_bus.data = ext_data_o;
  end

  // Count array requests and busy cycles
  always @(posedge ref_clk_i) begin
    if (|{flash_req_o.rd, flash_req_o.wr, flash_req_o.erase, flash_req_o.mass} === 1'b1)
      req_cnt <= req_cnt + 1;
    if (ext_ready_o === 1'b0)
      low_cnt <= low_cnt + 1;
  end

  flash_command_lock_control #(.ERASE_CYCLES(20), .MASS_CYCLES(20))
      u_flash_command_lock_control (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .code_read_external_i(code_read_external_i),
    .internal_fetch_block_o(internal_fetch_block_o),
    .external_access_select_o(external_access_select_o), .ext_pins_i(pin_bus),
    .ext_data_o(ext_data_o), .ext_data_oe_o(ext_data_oe_o), .ext_ready_o(ext_ready_o),
    .flash_req_o(flash_req_o), .flash_rdata_i(flash_rdata_i));

  flash_array_model u_flash_array_model (
    .ref_clk_i(ref_clk_i), .req_i(flash_req_o), .rdata_o(flash_rdata_i));

  // ----------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------
  task automatic cpu_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr_i <= 1'b0;
  endtask : cpu_wr

  task automatic cpu_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    sfr_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    d = sfr_rdata_o;
  endtask : cpu_rd

  task automatic wait_idle(output logic [7:0] d);
    for (int i = 0; i < 5000; i++) begin
      cpu_rd(ADDR_CMD, d);
      if (d[7:6] === 2'b11)
        break;
    end
  endtask : wait_idle

  // Pins set up, strobe low until ready returns, then released
  task automatic ext_op(input logic [3:0] m, input logic [12:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    pins.prog_en <= 1'b1;
    pins.mode <= m;
    pins.addr <= a;
    pins.data <= d;
    low_cnt = 0;
    repeat (4) @(posedge ref_clk_i);
    pins.strobe_n <= 1'b0;
    repeat (12) @(posedge ref_clk_i);
    for (int i = 0; i < 4000 && ext_ready_o !== 1'b1; i++)
      @(posedge ref_clk_i);
    pins.strobe_n <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : ext_op

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    miscompares++;
    summarize();
  end

  initial begin
    repeat (8) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk_bit(ext_ready_o, 1'b1);
    chk_byte(sfr_rdata_o, 8'h00);
    @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    cpu_rd(ADDR_CMD, s);
    chk_byte(s, {2'b11, CMD_RST});
    foreach (ROWS[i]) begin
      n0 = req_cnt;
      cpu_wr(ADDR_AHI, ROWS[i].ahi);
      cpu_wr(ADDR_ALO, ROWS[i].alo);
      cpu_wr(ADDR_DATA, ROWS[i].wd);
      cpu_wr(ADDR_CMD, ROWS[i].cmd);
      cpu_rd(ADDR_CMD, s);
      if (ROWS[i].busy)
        chk_byte(s, {~ROWS[i].ahi[7], ROWS[i].ahi[7], ROWS[i].cmd[5:0]});
      wait_idle(s);
      chk_byte(s, {2'b11, ROWS[i].cmd[5:0]});
      chk_byte(8'(req_cnt - n0), {7'h00, ROWS[i].reqs});
      if (ROWS[i].cmd == CMD_READ) begin
        cpu_rd(ADDR_DATA, s);
        chk_byte(s, ROWS[i].exp);
      end
    end
    // External program, verify and signatures with no locks
    @(posedge ref_clk_i);
    code_read_external_i <= 1'b1;
    pins.access_select <= 1'b1;
    ext_op(MODE_PROGRAM, 13'h0010, 8'h5a);
    chk_bit(low_cnt >= WRITE_CYCLES && low_cnt <= WR_MAX, 1'b1);
    chk_bit(internal_fetch_block_o, 1'b0);
    chk_bit(external_access_select_o, 1'b1);
    ext_op(MODE_VERIFY, 13'h0010, 8'h00);
    chk_bit(ext_data_oe_o, 1'b1);
    chk_byte(ext_data_o, 8'h5a);
    for (int k = 0; k < 3; k++) begin
      ext_op(MODE_SIG, {5'h00, SIG_ADDR0 + 8'(k)}, 8'h00);
      chk_byte(ext_data_o, k == 0 ? SIG_CONT : k == 1 ? SIG_MAKER : SIG_PART);
    end
    // Lock one: table reads blocked, programming refused, verify kept
    ext_op(MODE_LOCK1, 13'h0000, 8'h00);
    chk_bit(internal_fetch_block_o, 1'b1);
    chk_bit(external_access_select_o, 1'b0);
    ext_op(MODE_PROGRAM, 13'h0010, 8'h00);
    chk_bit(low_cnt == 0, 1'b1);
    ext_op(MODE_VERIFY, 13'h0010, 8'h00);
    chk_byte(ext_data_o, 8'h5a);
    // Lock two: verify refused; lock three: access pin overridden
    ext_op(MODE_LOCK2, 13'h0000, 8'h00);
    ext_op(MODE_VERIFY, 13'h0010, 8'h00);
    chk_bit(ext_data_oe_o, 1'b0);
    ext_op(MODE_LOCK3, 13'h0000, 8'h00);
    chk_bit(external_access_select_o, 1'b1);
    // Mass erase clears the array and every lock
    ext_op(MODE_MASS, 13'h0000, 8'h00);
    chk_bit(internal_fetch_block_o, 1'b0);
    ext_op(MODE_VERIFY, 13'h0010, 8'h00);
    chk_bit(ext_data_oe_o, 1'b1);
    chk_byte(ext_data_o, 8'hff);
    summarize();
  end
endmodule : testbench
